/* rtl/wrcm_defs.svh */
// Constants for the wireless receiver communication and mode controller.
// Assumes a 200 MHz system clock; times are given in their own units.
`ifndef WRCM_DEFS_SVH
`define WRCM_DEFS_SVH
`define WRCM_CLK_MHZ 200
`define WRCM_HALF_BIT_US 250
`define WRCM_HALF_BIT_CYC (`WRCM_HALF_BIT_US * `WRCM_CLK_MHZ)
`define WRCM_BIAS_MS 24
`define WRCM_PRIO_MS 35
`define WRCM_STD_MS 235
`define WRCM_DEGLITCH_US 100
`define WRCM_MS_CYC (1000 * `WRCM_CLK_MHZ)
`define WRCM_DEGLITCH_CYC (`WRCM_DEGLITCH_US * `WRCM_CLK_MHZ)
`define WRCM_HDR_RX_POWER 8'h04
`define WRCM_PREAMBLE_BITS 5'd11
`define WRCM_FRAME_BITS 4'd11
`define WRCM_FIXED_LIMIT_MA 12'd400
`define WRCM_MODE_THRESH_MA 12'd300
`define WRCM_TRACK_OFFSET_MA 12'd50
`endif

/* rtl/wrcm_pkg.sv */
// Types shared by the controller files.
// Assumes wrcm_defs.svh for the numeric constants.
package wrcm_pkg;
    typedef enum logic [1:0] {
        WRCM_RECT_DIODE = 2'b00,
        WRCM_RECT_HALF = 2'b01,
        WRCM_RECT_FULL = 2'b10
    } wrcm_rect_e;
    typedef enum logic [2:0] {
        WRCM_TX_IDLE = 3'b000,
        WRCM_TX_PRE = 3'b001,
        WRCM_TX_BYTE = 3'b010,
        WRCM_TX_SUM = 3'b011
    } wrcm_tx_e;
    typedef enum logic [1:0] {
        WRCM_TS_BIAS = 2'b00,
        WRCM_TS_WATCH = 2'b01
    } wrcm_ts_e;
    typedef logic [11:0] wrcm_ma_t;
endpackage

/* rtl/wrcm_buf2.sv */
// Two-entry valid/ready buffer for packet bytes.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module wrcm_buf2 (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [8:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [8:0] out_data
);
    logic [8:0] slot [0:1];
    logic rd_idx;
    logic wr_idx;
    logic [1:0] count;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = (count != 2'd2);
    assign out_valid = (count != 2'd0);
    assign out_data = slot[rd_idx];

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            count <= 2'd0;
            rd_idx <= 1'b0;
            wr_idx <= 1'b0;
        end else begin
            if (push) begin
                wr_idx <= ~wr_idx;
            end
            if (pop) begin
                rd_idx <= ~rd_idx;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            slot[wr_idx] <= in_data;
        end
    end
endmodule

/* rtl/wrcm_ctrl.sv */
// Communication and mode controller of a wireless power receiver.
// Assumes measured currents in mA and analog comparator levels as
// synchronous inputs; packet bytes arrive over a valid/ready port.
`timescale 1ns/1ps
`include "wrcm_defs.svh"

module wrcm_ctrl #(
    // Timing in clock cycles; a bench may shorten them to save run time
    parameter int HALF_BIT_CYC = `WRCM_HALF_BIT_CYC,
    parameter int MS_CYC = `WRCM_MS_CYC,
    parameter int DEGLITCH_CYC = `WRCM_DEGLITCH_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Packet byte stream; last marks final message byte
    input wire logic pkt_valid,
    output logic pkt_ready,
    input wire logic [7:0] pkt_byte,
    input wire logic pkt_last,
    // Request to send a received power report as next header
    input wire logic power_report,
    // Modulation switches
    output logic mod_switch_a,
    output logic mod_switch_b,
    output logic packet_busy,
    // Current limit
    input wire wrcm_pkg::wrcm_ma_t out_current_ma,
    output wrcm_pkg::wrcm_ma_t comm_limit_ma,
    output logic comm_limit_en,
    // Rectifier control
    input wire logic above_lockout,
    input wire logic above_full_sync_on,
    input wire logic below_full_sync_off,
    output wrcm_pkg::wrcm_rect_e rect_mode,
    // Temperature sense and control pin
    input wire logic ts_hot_cmp,
    input wire logic ts_cold_cmp,
    input wire logic temp_sense_ctl_pin_high_cmp,
    input wire logic priority_period,
    output logic sense_read_strobe,
    output logic temp_sense_ctl_pin_o,
    output logic temp_sense_ctl_pin_oe,
    output logic temp_hot,
    output logic temp_cold,
    output logic ctrl_input
);
    import wrcm_pkg::*;

    // ------------------------------------------------------------
    // Packet byte buffer
    // ------------------------------------------------------------
    logic buf_valid;
    logic buf_ready;
    logic [8:0] buf_data;
    logic [8:0] in_word;
    logic hdr_next;

    // A report request forces the header byte of the next packet
    assign in_word = {pkt_last,
        (hdr_next && power_report) ? `WRCM_HDR_RX_POWER : pkt_byte};

    wrcm_buf2 u_buf (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .in_valid(pkt_valid),
        .in_ready(pkt_ready),
        .in_data(in_word),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            hdr_next <= 1'b1;
        end else if (pkt_valid && pkt_ready) begin
            hdr_next <= pkt_last;
        end
    end

    // ------------------------------------------------------------
    // Serialiser
    // ------------------------------------------------------------
    function automatic logic [10:0] frame_of(input logic [7:0] b);
        frame_of = {1'b1, ~(^b), b, 1'b0};
    endfunction

    wrcm_tx_e tx_state;
    logic [10:0] shreg;
    logic [4:0] bit_cnt;
    logic [7:0] csum;
    logic half;
    logic [15:0] half_cnt;
    logic half_end;
    logic bit_end;
    logic cur_bit;
    logic mod_level;
    logic last_seen;

    assign half_end = (half_cnt == 16'(HALF_BIT_CYC - 1));
    assign bit_end = half_end && half;
    assign cur_bit = (tx_state == WRCM_TX_PRE) ? 1'b1 : shreg[0];
    assign buf_ready =
        (tx_state == WRCM_TX_BYTE && bit_end &&
         bit_cnt == 5'(`WRCM_FRAME_BITS - 1) && !last_seen) ||
        (tx_state == WRCM_TX_PRE && bit_end &&
         bit_cnt == `WRCM_PREAMBLE_BITS - 5'd1);

    always_ff @(posedge sys_clk) begin
        if (!reset_n || tx_state == WRCM_TX_IDLE) begin
            half_cnt <= 16'h0000;
            half <= 1'b0;
        end else if (half_end) begin
            half_cnt <= 16'h0000;
            half <= ~half;
        end else begin
            half_cnt <= half_cnt + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            tx_state <= WRCM_TX_IDLE;
            shreg <= 11'h000;
            bit_cnt <= 5'h00;
            csum <= 8'h00;
            last_seen <= 1'b0;
        end else begin
            case (tx_state)
                WRCM_TX_IDLE: begin
                    if (buf_valid) begin
                        // Hold byte in buffer until preamble ends
                        tx_state <= WRCM_TX_PRE;
                        bit_cnt <= 5'h00;
                        csum <= 8'h00;
                    end
                end
                WRCM_TX_PRE: begin
                    if (bit_end) begin
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == `WRCM_PREAMBLE_BITS - 5'd1) begin
                            tx_state <= WRCM_TX_BYTE;
                            bit_cnt <= 5'h00;
                            shreg <= frame_of(buf_data[7:0]);
                            csum <= buf_data[7:0];
                            last_seen <= buf_data[8];
                        end
                    end
                end
                WRCM_TX_BYTE, WRCM_TX_SUM: begin
                    if (bit_end) begin
                        shreg <= {1'b0, shreg[10:1]};
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == 5'(`WRCM_FRAME_BITS - 1)) begin
                            bit_cnt <= 5'h00;
                            if (tx_state == WRCM_TX_SUM) begin
                                tx_state <= WRCM_TX_IDLE;
                            end else if (last_seen) begin
                                tx_state <= WRCM_TX_SUM;
                                shreg <= frame_of(csum);
                            end else if (buf_valid) begin
                                shreg <= frame_of(buf_data[7:0]);
                                csum <= csum ^ buf_data[7:0];
                                last_seen <= buf_data[8];
                            end else begin
                                // Source underran; close with checksum
                                tx_state <= WRCM_TX_SUM;
                                shreg <= frame_of(csum);
                            end
                        end
                    end
                end
                default: begin
                    tx_state <= WRCM_TX_IDLE;
                end
            endcase
        end
    end

    // Level toggles at every bit start, and mid-bit for a one
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            mod_level <= 1'b0;
        end else if (tx_state == WRCM_TX_IDLE) begin
            // Entering the first bit is that bit's start transition
            mod_level <= buf_valid;
        end else if (tx_state == WRCM_TX_SUM && bit_end &&
                bit_cnt == 5'(`WRCM_FRAME_BITS - 1)) begin
            // Final edge only reopens the switches, so the coil rests idle
            mod_level <= 1'b0;
        end else if (half_end && (half || cur_bit)) begin
            mod_level <= ~mod_level;
        end
    end

    // Both switches share one level, so capacitors sit across the coil
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            mod_switch_a <= 1'b0;
            mod_switch_b <= 1'b0;
        end else begin
            mod_switch_a <= mod_level;
            mod_switch_b <= mod_level;
        end
    end

    assign packet_busy = (tx_state != WRCM_TX_IDLE);

    // ------------------------------------------------------------
    // Communication current limit
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            comm_limit_en <= 1'b0;
            comm_limit_ma <= 12'h000;
        end else begin
            comm_limit_en <= packet_busy;
            if (out_current_ma > `WRCM_MODE_THRESH_MA) begin
                comm_limit_ma <= out_current_ma +
                    `WRCM_TRACK_OFFSET_MA;
            end else begin
                comm_limit_ma <= `WRCM_FIXED_LIMIT_MA;
            end
        end
    end

    // ------------------------------------------------------------
    // Rectifier sequencing
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rect_mode <= WRCM_RECT_DIODE;
        end else begin
            case (rect_mode)
                WRCM_RECT_DIODE: begin
                    if (above_lockout) begin
                        rect_mode <= WRCM_RECT_HALF;
                    end
                end
                WRCM_RECT_HALF: begin
                    if (above_full_sync_on) begin
                        rect_mode <= WRCM_RECT_FULL;
                    end
                end
                WRCM_RECT_FULL: begin
                    if (below_full_sync_off) begin
                        rect_mode <= WRCM_RECT_HALF;
                    end
                end
                default: begin
                    rect_mode <= WRCM_RECT_DIODE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Temperature sense and control window
    // ------------------------------------------------------------
    localparam int BIAS_CYC = `WRCM_BIAS_MS * MS_CYC;
    localparam int PRIO_CYC = `WRCM_PRIO_MS * MS_CYC;
    localparam int STD_CYC = `WRCM_STD_MS * MS_CYC;
    localparam int DGL_CYC = DEGLITCH_CYC;

    wrcm_ts_e ts_state;
    logic [27:0] ts_cnt;
    logic [27:0] watch_len;
    logic [15:0] hot_cnt;
    logic [15:0] cold_cnt;

    assign watch_len = priority_period ? 28'(PRIO_CYC) : 28'(STD_CYC);

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ts_state <= WRCM_TS_BIAS;
            ts_cnt <= 28'h0000000;
        end else begin
            ts_cnt <= ts_cnt + 28'h0000001;
            case (ts_state)
                WRCM_TS_BIAS: begin
                    if (ts_cnt == 28'(BIAS_CYC - 1)) begin
                        ts_state <= WRCM_TS_WATCH;
                        ts_cnt <= 28'h0000000;
                    end
                end
                WRCM_TS_WATCH: begin
                    if (ts_cnt >= watch_len - 28'h0000001) begin
                        ts_state <= WRCM_TS_BIAS;
                        ts_cnt <= 28'h0000000;
                    end
                end
                default: begin
                    ts_state <= WRCM_TS_BIAS;
                end
            endcase
        end
    end

    // Pin driven high as bias only during the strobe, else released
    assign sense_read_strobe = (ts_state == WRCM_TS_BIAS);
    assign temp_sense_ctl_pin_o = 1'b1;
    assign temp_sense_ctl_pin_oe = sense_read_strobe;

    // Comparator must hold for the deglitch time within the strobe
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            hot_cnt <= 16'h0000;
            cold_cnt <= 16'h0000;
            temp_hot <= 1'b0;
            temp_cold <= 1'b0;
        end else if (sense_read_strobe) begin
            hot_cnt <= ts_hot_cmp ? hot_cnt + 16'h0001 : 16'h0000;
            cold_cnt <= ts_cold_cmp ? cold_cnt + 16'h0001 : 16'h0000;
            // New reading starts clean; a set in the same cycle wins
            if (ts_cnt == 28'h0000000) begin
                temp_hot <= 1'b0;
                temp_cold <= 1'b0;
            end
            if (hot_cnt == 16'(DGL_CYC - 1)) begin
                temp_hot <= 1'b1;
            end
            if (cold_cnt == 16'(DGL_CYC - 1)) begin
                temp_cold <= 1'b1;
            end
        end else begin
            hot_cnt <= 16'h0000;
            cold_cnt <= 16'h0000;
        end
    end

    // Control is latched per window; reloaded from the pin when a new one opens
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ctrl_input <= 1'b0;
        end else if (ts_state == WRCM_TS_WATCH) begin
            if (ts_cnt == 28'h0000000) begin
                ctrl_input <= temp_sense_ctl_pin_high_cmp;
            end else if (temp_sense_ctl_pin_high_cmp) begin
                ctrl_input <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    switches_in_step_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n) mod_switch_a == mod_switch_b)
        else $error("modulation switches differ");
    limit_follows_pkt_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n) packet_busy |=> comm_limit_en)
        else $error("comm limit not applied during packet");
    limit_released_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n) !packet_busy |=> !comm_limit_en)
        else $error("comm limit held after packet");
    fixed_limit_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n) out_current_ma <= `WRCM_MODE_THRESH_MA
        |=> comm_limit_ma == `WRCM_FIXED_LIMIT_MA)
        else $error("fixed limit wrong");
    track_limit_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n) out_current_ma > `WRCM_MODE_THRESH_MA
        |=> comm_limit_ma == $past(out_current_ma) + `WRCM_TRACK_OFFSET_MA)
        else $error("tracking limit wrong");
    no_diode_return_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n) rect_mode != WRCM_RECT_DIODE
        |=> rect_mode != WRCM_RECT_DIODE)
        else $error("rectifier fell back to diode");
    full_exit_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        rect_mode == WRCM_RECT_FULL && below_full_sync_off
        |=> rect_mode == WRCM_RECT_HALF)
        else $error("full sync did not exit");
    pin_released_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        ts_state == WRCM_TS_WATCH
        |-> !sense_read_strobe && !temp_sense_ctl_pin_oe)
        else $error("sense pin driven outside strobe");
    ctrl_detect_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        ts_state == WRCM_TS_WATCH && temp_sense_ctl_pin_high_cmp |=> ctrl_input)
        else $error("control input missed");
    odd_parity_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        tx_state == WRCM_TX_BYTE && bit_cnt == 5'h00 && half_cnt == 16'h0000
        && !half |-> ^shreg[9:1] == 1'b1 && !shreg[0] && shreg[10])
        else $error("byte frame malformed");
    cov_report_c: cover property (@(posedge sys_clk)
        tx_state == WRCM_TX_SUM && bit_end);
    cov_full_sync_c: cover property (@(posedge sys_clk)
        rect_mode == WRCM_RECT_FULL);
    cov_ctrl_c: cover property (@(posedge sys_clk) $rose(ctrl_input));
endmodule

/* tb/wrcm_tx_demod.sv */
// Transmitter-side demodulator model watching the two load switches.
// Assumes a 200 MHz clock; bits are decoded from the spacing of edges.
`timescale 1ns/1ps
`include "wrcm_defs.svh"
module wrcm_tx_demod #(
    // Half a bit period in clock cycles
    parameter int half_cyc = `WRCM_HALF_BIT_CYC
) (
    // Clock
    input wire logic sys_clk,
    // Coil load seen through the coupling
    input wire logic mod_switch_a,
    input wire logic mod_switch_b,
    // Decoded bits and coding faults
    output logic bit_stb,
    output logic bit_val,
    output int err_cnt
);
    logic last_a = 1'b0;
    logic busy = 1'b0;
    logic mid = 1'b0;
    int gap = 0;
    initial begin
        bit_stb = 1'b0;
        bit_val = 1'b0;
        err_cnt = 0;
    end
    // ----------------------------------------------------------------
    // Bi-phase decoder
    // ----------------------------------------------------------------
    // Edge spacing must be exactly a half or a whole bit; a real
    // demodulator tolerates jitter, this one flags any slip at all.
    always @(posedge sys_clk) begin
        bit_stb <= 1'b0;
        gap <= gap + 1;
        if (mod_switch_a !== mod_switch_b) begin
            err_cnt <= err_cnt + 1;
        end
        if (busy && gap > 3 * half_cyc) begin
            busy <= 1'b0;
        end
        // Unknown before the first reset edge is not a transition
        if (mod_switch_a !== last_a && !$isunknown(mod_switch_a)) begin
            last_a <= mod_switch_a;
            gap <= 1;
            if (!busy || gap > 3 * half_cyc) begin
                busy <= 1'b1;
                mid <= 1'b0;
            end else if (mid) begin
                mid <= 1'b0;
                if (gap != half_cyc) begin
                    err_cnt <= err_cnt + 1;
                end
            end else if (gap == half_cyc) begin
                mid <= 1'b1;
                bit_stb <= 1'b1;
                bit_val <= 1'b1;
            end else if (gap == 2 * half_cyc) begin
                bit_stb <= 1'b1;
                bit_val <= 1'b0;
            end else begin
                err_cnt <= err_cnt + 1;
            end
        end
    end
endmodule

/* tb/test_wireless_rx_comm_and_mode_control.sv */
// Testbench for the receiver communication and mode controller.
// Assumes wrcm_tx_demod as the transmitter; timing is scaled down to fit.
`timescale 1ns/1ps
`include "wrcm_defs.svh"
`define CHECK(nm, got, exp) begin checks++; if ((got) !== (exp)) begin \
    fails++; $display("Error %s expected %0h seen %0h", nm, exp, got); \
    end end
module test_wireless_rx_comm_and_mode_control;
    import wrcm_pkg::*;
    // Shortened timing keeps the run near 17k cycles
    localparam int TB_HALF = 20;
    localparam int TB_MS = 40;
    localparam int TB_DGL = 20;
    logic sys_clk = 1'b0, reset_n = 1'b0;
    logic pkt_valid = 1'b0, pkt_ready, pkt_last = 1'b0;
    logic [7:0] pkt_byte = 8'h00;
    logic power_report = 1'b0, mod_switch_a, mod_switch_b, packet_busy;
    wrcm_ma_t out_current_ma = 12'd200, comm_limit_ma;
    logic comm_limit_en, above_lockout = 1'b0;
    logic above_full_sync_on = 1'b0, below_full_sync_off = 1'b0;
    wrcm_rect_e rect_mode;
    logic ts_hot_cmp = 1'b0, ts_cold_cmp = 1'b0, temp_sense_ctl_pin_high_cmp = 1'b0;
    logic priority_period = 1'b1, sense_read_strobe;
    logic temp_sense_ctl_pin_o, temp_sense_ctl_pin_oe;
    logic temp_hot, temp_cold, ctrl_input, bit_stb, bit_val;
    int err_cnt, fails = 0, checks = 0, stalls;
    logic bits[$], exp_q[$];

    wrcm_ctrl #(.HALF_BIT_CYC(TB_HALF), .MS_CYC(TB_MS),
        .DEGLITCH_CYC(TB_DGL)) dut (.sys_clk, .reset_n, .pkt_valid,
        .pkt_ready, .pkt_byte,
        .pkt_last, .power_report, .mod_switch_a, .mod_switch_b,
        .packet_busy, .out_current_ma, .comm_limit_ma, .comm_limit_en,
        .above_lockout, .above_full_sync_on, .below_full_sync_off,
        .rect_mode, .ts_hot_cmp, .ts_cold_cmp, .temp_sense_ctl_pin_high_cmp,
        .priority_period, .sense_read_strobe, .temp_sense_ctl_pin_o,
        .temp_sense_ctl_pin_oe, .temp_hot, .temp_cold, .ctrl_input);
    wrcm_tx_demod #(.half_cyc(TB_HALF)) demod (.sys_clk, .mod_switch_a,
        .mod_switch_b, .bit_stb,
        .bit_val, .err_cnt);

    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (bit_stb === 1'b1) begin
            bits.push_back(bit_val);
        end
    end

    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic stop_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset;
        `CHECK("rect", rect_mode, WRCM_RECT_DIODE)
        `CHECK("strobe", sense_read_strobe, 1'b1)
        `CHECK("pin_oe", temp_sense_ctl_pin_oe, 1'b1)
        `CHECK("pin_o", temp_sense_ctl_pin_o, 1'b1)
        `CHECK("switch", {mod_switch_a, mod_switch_b}, 2'b00)
        `CHECK("limit_en", comm_limit_en, 1'b0)
        `CHECK("ready", pkt_ready, 1'b1)
        $display("test_reset done");
    endtask

    task automatic test_rect;
        logic [2:0] cmp [6] = '{3'b010, 3'b100, 3'b110, 3'b100, 3'b101,
            3'b110};
        wrcm_rect_e exp [6] = '{WRCM_RECT_DIODE, WRCM_RECT_HALF,
            WRCM_RECT_FULL, WRCM_RECT_FULL, WRCM_RECT_HALF, WRCM_RECT_FULL};
        for (int i = 0; i < 6; i++) begin
            {above_lockout, above_full_sync_on, below_full_sync_off} = cmp[i];
            repeat (3) tick;
            `CHECK("rect", rect_mode, exp[i])
        end
        $display("test_rect done");
    endtask

    // Window must last len cycles; control is reloaded, then latches a high pin
    task automatic watch_window(input int len);
        int n;
        n = 0;
        while (sense_read_strobe === 1'b0 && n < 100000) begin
            if (n == 1000) begin
                `CHECK("ctrl", ctrl_input, 1'b0)
                temp_sense_ctl_pin_high_cmp = 1'b1;
            end
            if (n == 1003) begin
                `CHECK("ctrl", ctrl_input, 1'b1)
                temp_sense_ctl_pin_high_cmp = 1'b0;
            end
            tick;
            n++;
        end
        `CHECK("window", n, len)
    endtask

    task automatic test_sense;
        int n;
        n = 0;
        while (sense_read_strobe !== 1'b0 && n < 100000) begin
            tick;
            n++;
        end
        `CHECK("pin_oe", temp_sense_ctl_pin_oe, 1'b0)
        watch_window(`WRCM_PRIO_MS * TB_MS);
        n = 0;
        while (sense_read_strobe === 1'b1 && n < 100000) begin
            if (n == 10) begin
                ts_hot_cmp = 1'b1;
                ts_cold_cmp = 1'b1;
            end
            if (n == 10 + TB_DGL / 2) begin
                ts_cold_cmp = 1'b0;
            end
            if (n == 15 + TB_DGL) begin
                `CHECK("hot", temp_hot, 1'b1)
                `CHECK("cold", temp_cold, 1'b0)
                `CHECK("pin_oe", temp_sense_ctl_pin_oe, 1'b1)
                ts_hot_cmp = 1'b0;
            end
            tick;
            n++;
        end
        `CHECK("bias", n, `WRCM_BIAS_MS * TB_MS)
        // Standard period: longer window, and hot cleared at next strobe
        priority_period = 1'b0;
        watch_window(`WRCM_STD_MS * TB_MS);
        tick;
        `CHECK("hot clear", temp_hot, 1'b0)
        $display("test_sense done");
    endtask

    task automatic add_frame(input logic [7:0] b);
        logic [10:0] fr;
        fr = {1'b1, ~^b, b, 1'b0};
        for (int j = 0; j < 11; j++) begin
            exp_q.push_back(fr[j]);
        end
    endtask

    // Bytes go in back to back so the buffer never runs dry mid-packet
    task automatic send_packet(input logic [7:0] b[$], input logic rep,
            input wrcm_ma_t cur, input wrcm_ma_t lim);
        logic [7:0] sum;
        int n;
        out_current_ma = cur;
        bits.delete();
        exp_q.delete();
        repeat (11) exp_q.push_back(1'b1);
        sum = rep ? `WRCM_HDR_RX_POWER : b[0];
        add_frame(sum);
        for (int i = 1; i < b.size(); i++) begin
            add_frame(b[i]);
            sum ^= b[i];
        end
        add_frame(sum);
        power_report = rep;
        stalls = 0;
        foreach (b[i]) begin
            pkt_valid = 1'b1;
            pkt_byte = b[i];
            pkt_last = (i == b.size() - 1);
            n = 0;
            while (pkt_ready !== 1'b1 && n < 2000000) begin
                tick;
                n++;
            end
            stalls += n;
            tick;
            power_report = 1'b0;
        end
        pkt_valid = 1'b0;
        pkt_last = 1'b0;
        // A lone byte needs two edges to start the packet and its limit
        repeat (2) tick;
        `CHECK("busy", packet_busy, 1'b1)
        `CHECK("limit_en", comm_limit_en, 1'b1)
        `CHECK("limit", comm_limit_ma, lim)
        n = 0;
        while (packet_busy !== 1'b0 && n < 8000000) begin
            tick;
            n++;
        end
        repeat (3) tick;
        `CHECK("limit_en", comm_limit_en, 1'b0)
        // The demodulator needs a quiet line to spot the next packet
        repeat (4 * TB_HALF) tick;
        n = 0;
        for (int k = 0; k < bits.size() && k < exp_q.size(); k++) begin
            n += (bits[k] !== exp_q[k]);
        end
        `CHECK("bit count", bits.size(), exp_q.size())
        `CHECK("bit errors", n, 0)
        `CHECK("code errors", err_cnt, 0)
    endtask

    task automatic test_report_packet;
        send_packet('{8'h55, 8'ha3, 8'h00, 8'hff}, 1'b1, 12'd301, 12'd351);
        `CHECK("stalled", stalls > 0, 1'b1)
        $display("test_report_packet done");
    endtask

    task automatic test_header_packet;
        send_packet('{8'h80}, 1'b0, 12'd300, 12'd400);
        $display("test_header_packet done");
    endtask

    initial begin
        #(200_000);
        fails++;
        $display("Error watchdog expected 0 seen 1");
        stop_test;
    end

    initial begin
        repeat (4) tick;
        reset_n = 1'b1;
        tick;
        test_reset;
        test_rect;
        test_sense;
        test_report_packet;
        test_header_packet;
        stop_test;
    end
endmodule
